/* File: hw/chan_status_flags.sv */
/*
 * per-channel done and error status flag bank with done interrupt
 * assumes event pulses come from logic on mclk; host port is synchronous
 */
`timescale 1ns/1ns
`default_nettype none

// Function
// - bits 15..0 of the second done word report done for channels 32..47.
// - writing one clears a done flag and writing zero leaves it alone, except channels 2, 31, 32 and 35.
// - the word at 0x011c holds error flags for channels 0..31.
// - the word at 0x0120 holds error flags for channels 32..63.
// - an error flag other than channel 31 stays set until software writes one to it.
// - all done and error flags read zero after reset.
// - error flag of channel 31 is plain read-write.
// - done flags of channels 35 and 32 are plain read-write.
// - done flags for channels 0..31 sit in the word at 0x0114.
// - the enable word at 0x0124 gates the irq from done flags of channels 0..31.
module chan_status_flags
    import chan_status_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire host_req_t   host_req,
    input  wire logic [63:0] done_evt,
    input  wire logic [63:0] err_evt,
    output logic [31:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             irq
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    // release is synchronised so every flag leaves reset on the same edge
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------------
    // hardware set wins over a same-cycle clear so no event is lost
    function automatic logic [31:0] upd(
        input logic [31:0] cur,
        input logic [31:0] rw_mask,
        input logic        hit,
        input logic [31:0] wd,
        input logic [31:0] evt
    );
        logic [31:0] v;
        v = cur;
        if (hit)
        begin
            v = (rw_mask & wd) | (~rw_mask & cur & ~wd);
        end
        return v | evt;
    endfunction

    flags_t      flags_reg;
    flags_t      flags_next;
    logic [31:0] ena_reg;
    logic [31:0] ena_next;
    logic [31:0] rdata_next;
    logic        irq_next;
    logic        wr_dl;
    logic        wr_dh;
    logic        wr_el;
    logic        wr_eh;

    always_comb
    begin
        wr_dl = host_req.wr && host_req.addr == DONE_LOW_OFS;
        wr_dh = host_req.wr && host_req.addr == DONE_HIGH_OFS;
        wr_el = host_req.wr && host_req.addr == ERR_LOW_OFS;
        wr_eh = host_req.wr && host_req.addr == ERR_HIGH_OFS;
        flags_next.done_low  = upd(flags_reg.done_low, DONE_LOW_RW_MASK,
                                   wr_dl, host_req.wdata, done_evt[31:0]);
        flags_next.done_high = upd(flags_reg.done_high, DONE_HIGH_RW_MASK,
                                   wr_dh, host_req.wdata, done_evt[63:32]);
        flags_next.err_low   = upd(flags_reg.err_low, ERR_LOW_RW_MASK,
                                   wr_el, host_req.wdata, err_evt[31:0]);
        flags_next.err_high  = upd(flags_reg.err_high, ERR_HIGH_RW_MASK,
                                   wr_eh, host_req.wdata, err_evt[63:32]);
        ena_next = (host_req.wr && host_req.addr == DONE_ENA_OFS)
                 ? host_req.wdata : ena_reg;
        // only the low done word has enables here, so errors raise no irq
        // level from the registered flags and enables
        irq_next = |(flags_reg.done_low & ena_reg);
        // a read beside a write to the same word returns the old value
        unique case (host_req.addr)
            DONE_LOW_OFS:  rdata_next = flags_reg.done_low;
            DONE_HIGH_OFS: rdata_next = flags_reg.done_high;
            ERR_LOW_OFS:   rdata_next = flags_reg.err_low;
            ERR_HIGH_OFS:  rdata_next = flags_reg.err_high;
            DONE_ENA_OFS:  rdata_next = ena_reg;
            default:       rdata_next = 32'h0000_0000;
        endcase
        if (!host_req.rd)
        begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            flags_reg  <= {4{FLAGS_RESET}};
            ena_reg    <= ENA_RESET;
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            flags_reg  <= flags_next;
            ena_reg    <= ena_next;
            reg_rdata  <= rdata_next;
            reg_rvalid <= host_req.rd;
            irq        <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_reg);

    a_done_high_set: assert property (
        done_evt[40] |=> flags_reg.done_high[8])
        else $error("channel 40 done not set");
    a_done_w1c_clear: assert property (
        wr_dh && host_req.wdata[5] && !done_evt[37]
        |=> !flags_reg.done_high[5])
        else $error("done flag not cleared by one");
    a_err_low_set: assert property (
        err_evt[7] |=> flags_reg.err_low[7])
        else $error("channel 7 error not set");
    a_err_high_read: assert property (
        host_req.rd && host_req.addr == ERR_HIGH_OFS
        |=> reg_rvalid && reg_rdata == $past(flags_reg.err_high))
        else $error("high error word read mismatch");
    a_err_zero_write: assert property (
        wr_eh && host_req.wdata == 32'h0000_0000 && err_evt[63:32] == '0
        |=> flags_reg.err_high == $past(flags_reg.err_high))
        else $error("zero write altered error flags");
    // checked on the first enabled edge, since the disable hides reset
    a_reset_zero: assert property (
        $rose(rst_sync_reg) |-> flags_reg == '0 && ena_reg == '0 && !irq)
        else $error("flags not zero after reset");
    a_err31_rw: assert property (
        wr_el && host_req.wdata[31] |=> flags_reg.err_low[31])
        else $error("channel 31 error not writable");
    a_done35_rw: assert property (
        wr_dh && host_req.wdata[3] |=> flags_reg.done_high[3])
        else $error("channel 35 done not writable");
    a_done_low_read: assert property (
        host_req.rd && host_req.addr == DONE_LOW_OFS
        |=> reg_rdata == $past(flags_reg.done_low))
        else $error("low done word read mismatch");
    a_irq_follows: assert property (
        (flags_reg.done_low & ena_reg) != '0 |=> irq)
        else $error("irq missing");
    a_irq_drops: assert property (
        (flags_reg.done_low & ena_reg) == '0 |=> !irq)
        else $error("irq without enabled flag");

    // one bit stands for each access type; the other bits share its path
    a_err31_zero: assert property (
        wr_el && !host_req.wdata[31] && !err_evt[31]
        |=> !flags_reg.err_low[31])
        else $error("channel 31 error not cleared by zero");
    a_done32_rw: assert property (
        wr_dh && !host_req.wdata[0] && !done_evt[32]
        |=> !flags_reg.done_high[0])
        else $error("channel 32 done not writable");
    a_done47_set: assert property (
        done_evt[47] |=> flags_reg.done_high[15])
        else $error("channel 47 done not set");
    a_done_zero_keep: assert property (
        wr_dh && !host_req.wdata[15] && flags_reg.done_high[15]
        |=> flags_reg.done_high[15])
        else $error("zero write cleared a done flag");
    a_err_low_w1c: assert property (
        wr_el && host_req.wdata[4] && !err_evt[4]
        |=> !flags_reg.err_low[4])
        else $error("error flag not cleared by one");
    a_err_high_hold: assert property (
        !wr_eh && flags_reg.err_high[0] |=> flags_reg.err_high[0])
        else $error("error flag dropped without a write");
    a_err_high_set: assert property (
        err_evt[63] |=> flags_reg.err_high[31])
        else $error("channel 63 error not set");
    a_done_low_set: assert property (
        done_evt[2] |=> flags_reg.done_low[2])
        else $error("channel 2 done not set");
    a_ena_write: assert property (
        host_req.wr && host_req.addr == DONE_ENA_OFS
        |=> ena_reg == $past(host_req.wdata))
        else $error("enable word not written");


    c_irq_rise: cover property (!irq ##1 irq);
    c_set_and_clear: cover property (wr_eh && host_req.wdata[0] && err_evt[32]);
    c_err31_written: cover property (wr_el && host_req.wdata[31]);
    c_done_cleared: cover property (flags_reg.done_high[15] ##1
                                    !flags_reg.done_high[15]);

endmodule

`default_nettype wire

/* File: hw/chan_status_pkg.sv */
/*
 * constants, offsets and carrier types for the channel status flag bank
 * assumes a single clock domain and a 32-bit host register port
 */
package chan_status_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] DONE_LOW_OFS  = 12'h114;
    localparam logic [11:0] DONE_HIGH_OFS = 12'h118;
    localparam logic [11:0] ERR_LOW_OFS   = 12'h11c;
    localparam logic [11:0] ERR_HIGH_OFS  = 12'h120;
    localparam logic [11:0] DONE_ENA_OFS  = 12'h124;

    // ------------------------------------------------------------------
    // access masks: a one marks a plain read-write bit, zero write-one-clear
    // ------------------------------------------------------------------
    localparam logic [31:0] DONE_LOW_RW_MASK  = 32'h8000_0004;
    localparam logic [31:0] DONE_HIGH_RW_MASK = 32'h0000_0009;
    localparam logic [31:0] ERR_LOW_RW_MASK   = 32'h8000_0000;
    localparam logic [31:0] ERR_HIGH_RW_MASK  = 32'h0000_0000;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
    localparam logic [31:0] ENA_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] done_low;
        logic [31:0] done_high;
        logic [31:0] err_low;
        logic [31:0] err_high;
    } flags_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } host_req_t;

endpackage

/* File: verif/chan_status_flags_tb_top.sv */
/*
 * self-checking bench for the channel status flag bank
 * assumes the package is compiled first; the bench drives every port
 */
`timescale 1ns/1ns
`default_nettype none
module chan_status_flags_tb_top
    import chan_status_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [11:0] addr;
        logic [31:0] data;
    } row_t;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        mclk;
    logic        rst_b;
    host_req_t   host_req;
    logic [63:0] done_evt;
    logic [63:0] err_evt;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        irq;
    int          error_cnt;
    int          cmp_count;
    // read rows hold the expected value; flags start all set
    localparam row_t ROWS [0:15] = '{
        {1'b1, 12'h118, 32'h0000_ffff}, {1'b0, 12'h118, 32'hffff_0009},
        {1'b1, 12'h118, 32'h0000_0000}, {1'b0, 12'h118, 32'hffff_0000},
        {1'b1, 12'h11c, 32'h7fff_fff0}, {1'b0, 12'h11c, 32'h0000_000f},
        {1'b1, 12'h11c, 32'h8000_0000}, {1'b0, 12'h11c, 32'h8000_000f},
        {1'b1, 12'h120, 32'h0000_0001}, {1'b0, 12'h120, 32'hffff_fffe},
        {1'b1, 12'h120, 32'h0000_0000}, {1'b0, 12'h120, 32'hffff_fffe},
        {1'b1, 12'h200, 32'hffff_ffff}, {1'b0, 12'h200, 32'h0000_0000},
        {1'b1, 12'h114, 32'hffff_ffff}, {1'b0, 12'h114, 32'h8000_0004}};
    chan_status_flags u_chan_status_flags (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .host_req   (host_req),
        .done_evt   (done_evt),
        .err_evt    (err_evt),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid),
        .irq        (irq)
    );
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // one request cycle; events may share it, so set-versus-clear is seen
    task automatic xfer(input logic wr, input logic rd,
                        input logic [11:0] a, input logic [31:0] d,
                        input logic [63:0] de, input logic [63:0] ee);
        @(posedge mclk);
        host_req <= '{wr: wr, rd: rd, addr: a, wdata: d};
        done_evt <= de;
        err_evt  <= ee;
        @(posedge mclk);
        host_req <= '0;
        done_evt <= '0;
        err_evt  <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, 1'b1, a, 32'h0, 64'h0, 64'h0);
        #1;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, exp);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #100000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        host_req = '0;
        done_evt = '0;
        err_evt = '0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int i = 0; i < 5; i++)
            rd(12'h114 + 12'(4 * i), 32'h0);
        $display("test reset values done");
        xfer(1'b0, 1'b0, 12'h0, 32'h0, '1, '1);
        foreach (ROWS[i])
            if (ROWS[i].wr)
                xfer(1'b1, 1'b0, ROWS[i].addr, ROWS[i].data, 64'h0, 64'h0);
            else
                rd(ROWS[i].addr, ROWS[i].data);
        chk({31'h0, irq}, 32'h0);
        $display("test access rows done");
        xfer(1'b1, 1'b0, 12'h124, 32'h0000_0004, 64'h0, 64'h0);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, 1'b0, 12'h114, 32'h0, 64'h0, 64'h0);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, 1'b0, 12'h0, 32'h0, 64'h4, 64'h0);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h1);
        $display("test interrupt done");
        xfer(1'b1, 1'b0, 12'h118, 32'h0000_0100, 64'h1 << 40, 64'h0);
        rd(12'h118, 32'hffff_0100);
        xfer(1'b1, 1'b0, 12'h120, 32'h20, 64'h0, 64'h1 << 37);
        rd(12'h120, 32'hffff_fffe);
        xfer(1'b1, 1'b0, 12'h120, 32'h20, 64'h0, 64'h0);
        rd(12'h120, 32'hffff_ffde);
        $display("test set over clear done");
        // second reset in mid-run must wipe flags that are set
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(12'h118, 32'h0);
        rd(12'h120, 32'h0);
        rd(12'h114, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
`default_nettype wire
